// ===== include/sbcspi_pkg.sv
package sbcspi_pkg;

   // frame layout, most significant bit first on the wire
   localparam int FRAME_BITS = 16;
   localparam int CMD_HI     = 15;
   localparam int CMD_LO     = 14;
   localparam int ADDR_HI    = 13;
   localparam int ADDR_LO    = 9;
   localparam int PN_BIT     = 8;
   localparam int SUB_BIT    = 7;
   localparam int BYTE_BITS  = 8;

   // bit counts inside the link
   localparam logic [4:0] CNT_HEAD_LAST = 5'h06;
   localparam logic [4:0] CNT_SUB_LAST  = 5'h08;
   localparam logic [4:0] CNT_FIRST_LO  = 5'h08;
   localparam logic [4:0] CNT_WORD_LAST = 5'h0F;
   localparam logic [4:0] CNT_FULL      = 5'h10;

   typedef enum logic [1:0] {
      CMD_READ  = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_RSVD  = 2'b10,
      CMD_FLAG  = 2'b11
   } sbcspi_cmd_type;

   typedef struct packed {
      sbcspi_cmd_type cmd;
      logic [4:0]     addr;
      logic           pn;
      logic [7:0]     data;
   } sbcspi_frame_type;

   typedef struct packed {
      sbcspi_cmd_type cmd;
      logic [4:0]     addr;
   } sbcspi_head_type;

   // high byte answers sub-address high, low byte sub-address low
   typedef struct packed {
      logic [15:0] can;
      logic [15:0] io;
      logic [15:0] irq;
      logic [15:0] lin;
   } sbcspi_flags_type;

   // register addresses
   localparam int         NUM_REGS      = 20;
   localparam logic [4:0] ADDR_ANALOG   = 5'h00;
   localparam logic [4:0] ADDR_SCR_A    = 5'h01;
   localparam logic [4:0] ADDR_SCR_D    = 5'h04;
   localparam logic [4:0] ADDR_INIT_SUP = 5'h05;
   localparam logic [4:0] ADDR_INIT_MSC = 5'h08;
   localparam logic [4:0] ADDR_SPECIAL  = 5'h09;
   localparam logic [4:0] ADDR_PER_A    = 5'h0A;
   localparam logic [4:0] ADDR_PER_C    = 5'h0C;
   localparam logic [4:0] ADDR_WDOG     = 5'h0D;
   localparam logic [4:0] ADDR_MODE     = 5'h0E;
   localparam logic [4:0] ADDR_SUPPLY   = 5'h0F;
   localparam logic [4:0] ADDR_CAN      = 5'h10;
   localparam logic [4:0] ADDR_IO       = 5'h11;
   localparam logic [4:0] ADDR_IRQ      = 5'h12;
   localparam logic [4:0] ADDR_LIN      = 5'h13;

   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam int         PARITY_EN_BIT = 6;
   localparam int         MODE_DBG_BIT  = 7;

   // fixed status byte fields
   localparam int ST_SPI_ERR = 7;
   localparam int ST_DEBUG   = 6;
   localparam int ST_SPECIAL = 5;
   localparam int ST_LOWPWR  = 4;

   localparam logic [7:0] LFSR_SEED = 8'hA5;
   localparam logic [7:0] LFSR_TAPS = 8'hB8;

endpackage

// ===== rtl/sbcspi_sync.sv
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser; only the second stage is visible
module sbcspi_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,     // destination clock
   input  wire logic             reset,   // async reset, active high
   input  wire logic [WIDTH-1:0] asyncIn, // level from another domain
   output logic      [WIDTH-1:0] syncOut  // level in clk domain
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q  <= '0;
         syncOut <= '0;
      end
      else
      begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ===== rtl/sbcspi_link.sv
`timescale 1ns/1ns
`default_nettype none

// serial side, runs on the master's clock (mode 0)
module sbcspi_link (
   input  wire logic                       spiClk,    // serial clock
   input  wire logic                       reset,     // async reset
   input  wire logic                       csN,       // chip select
   input  wire logic                       mosi,      // serial data in
   input  wire logic [7:0]                 statusByte,// fixed status
   input  wire logic [7:0]                 respLo,    // answer, bit 7 low
   input  wire logic [7:0]                 respHi,    // answer, bit 7 high
   output logic                            reqTog,    // head ready toggle
   output sbcspi_pkg::sbcspi_head_type     reqHead,   // command, address
   output logic                            frameTog,  // word ready toggle
   output sbcspi_pkg::sbcspi_frame_type    frameWord, // received word
   output logic                            misoQ      // serial data out
);

   logic        frameRst;
   logic [4:0]  bitCnt_q;
   logic [14:0] rx_q;
   logic        subSel_q;
   logic [7:0]  statusSnap_q;
   logic [7:0]  second;

   assign frameRst = reset | csN;
   assign second   = subSel_q ? respHi : respLo;

   always_ff @(posedge spiClk or posedge frameRst)
   begin
      if (frameRst)
         bitCnt_q <= '0;
      else if (bitCnt_q != sbcspi_pkg::CNT_FULL)
         bitCnt_q <= bitCnt_q + 5'h01;
   end

   always_ff @(posedge spiClk or posedge reset)
   begin
      if (reset)
         rx_q <= '0;
      else
         rx_q <= {rx_q[13:0], mosi};
   end

   always_ff @(posedge spiClk or posedge reset)
   begin
      if (reset)
      begin
         reqTog  <= 1'b0;
         reqHead <= '0;
      end
      else if (bitCnt_q == sbcspi_pkg::CNT_HEAD_LAST)
      begin
         reqTog  <= ~reqTog;
         reqHead <= sbcspi_pkg::sbcspi_head_type'({rx_q[5:0], mosi});
      end
   end

   always_ff @(posedge spiClk or posedge reset)
   begin
      if (reset)
         subSel_q <= 1'b0;
      else if (bitCnt_q == sbcspi_pkg::CNT_SUB_LAST)
         subSel_q <= mosi;
   end

   // extra clocks beyond sixteen are ignored
   always_ff @(posedge spiClk or posedge reset)
   begin
      if (reset)
      begin
         frameTog  <= 1'b0;
         frameWord <= '0;
      end
      else if (bitCnt_q == sbcspi_pkg::CNT_WORD_LAST)
      begin
         frameTog  <= ~frameTog;
         frameWord <= sbcspi_pkg::sbcspi_frame_type'({rx_q, mosi});
      end
   end

   // output shifts on the falling edge; status for next frame at the end
   always_ff @(negedge spiClk or posedge reset)
   begin
      if (reset)
      begin
         misoQ        <= 1'b0;
         statusSnap_q <= '0;
      end
      else if (bitCnt_q == sbcspi_pkg::CNT_FULL)
      begin
         misoQ        <= statusByte[7];
         statusSnap_q <= statusByte;
      end
      else if (bitCnt_q < sbcspi_pkg::CNT_FIRST_LO)
         misoQ <= statusSnap_q[3'(5'h07 - bitCnt_q)];
      else if (bitCnt_q == sbcspi_pkg::CNT_FIRST_LO)
         misoQ <= respLo[7];
      else
         misoQ <= second[3'(5'h0F - bitCnt_q)];
   end

endmodule
`default_nettype wire

// ===== rtl/sbcspi_command_decoder.sv
// Summary of operation
// - bits 13..9 select the target register
// - read-back returns status then stored control bits
// - read with bit 7 returns bit 7 of the low answer, then identity bits 2..0 and pins
// - write returns fixed and extended status
// - flag read returns low flag byte, or its bit 7 then high byte bits 14..8
// - analog-select register stores and returns its bits
// - four scratch bytes store and return data
// - four start-up registers store and return bits
// - special mode needs inverted code; read gives code
// - three period registers store and return values
// - mode write selects low power; reads report mode
// - CAN, I/O, irq, LIN: control and flags
// - fixed status always in bits 15..8
`timescale 1ns/1ns
`default_nettype none

module sbcspi_command_decoder #(
   parameter logic [3:0] DEVICE_ID = 4'h6 // arbitrary identity value
) (
   input  wire logic                        mclk,          // core clock
   input  wire logic                        reset,         // async, high
   input  wire logic                        spiClk,        // serial clock
   input  wire logic                        csN,           // chip select
   input  wire logic                        mosi,          // serial in
   output logic                             miso,          // serial out
   output logic                             misoOe,        // miso drive
   input  wire logic [3:0]                  ioPins,        // I/O levels
   input  wire logic                        debugPin,      // debug strap
   input  wire sbcspi_pkg::sbcspi_flags_type deviceFlags,  // block flags
   output logic [sbcspi_pkg::NUM_REGS-1:0][7:0] regImage,  // control regs
   output logic                             wdRefresh,     // refresh pulse
   output logic                             lowPowerReq,   // mode pulse
   output logic                             specialActive, // special mode
   output logic                             debugMode      // in debug
);

   localparam int NR = sbcspi_pkg::NUM_REGS;

   // link side
   logic                         reqTog;
   logic                         frameTog;
   sbcspi_pkg::sbcspi_head_type  reqHead;
   sbcspi_pkg::sbcspi_frame_type frameWord;
   logic                         misoLink;

   // core side
   logic [5:0]          pinSync;
   logic [1:0]          togSync;
   logic                reqSeen_q;
   logic                frameSeen_q;
   logic                reqEdge;
   logic                frameEdge;
   logic [7:0]          respLo_q;
   logic [7:0]          respHi_q;
   logic [7:0]          status_q;
   logic [7:0]          lfsr_q;
   logic [7:0]          random_q;
   logic                spiErr_q;
   logic [2:0]          started_q;
   logic [7:0]          extStatus;
   logic                writeOk;
   logic                readOk;
   logic                badFrame;
   logic [NR-1:0][7:0]  regs_q;

   sbcspi_pkg::sbcspi_frame_type fw;

   assign fw = frameWord;
   assign miso = misoLink;
   assign regImage = regs_q;

   // parity over all bits except bit 8; when enabled, bit 8 high when the ones are even, else bit 8 low
   function automatic logic parity_ok(
      input sbcspi_pkg::sbcspi_frame_type f,
      input logic                         enable
   );
      logic ones;
      ones = ^{f.cmd, f.addr, f.data};
      if (enable)
         parity_ok = (f.pn == ~ones);
      else
         parity_ok = (f.pn == 1'b0);
   endfunction

   function automatic logic addr_mapped(input logic [4:0] a);
      addr_mapped = (a <= sbcspi_pkg::ADDR_LIN);
   endfunction

   // control read-back of a register
   function automatic logic [7:0] reg_read(
      input logic [4:0]         a,
      input logic [NR-1:0][7:0] r,
      input logic [7:0]         code,
      input logic               dbg
   );
      reg_read = sbcspi_pkg::REG_RESET;
      if (!addr_mapped(a))
         reg_read = sbcspi_pkg::REG_RESET;
      else if (a == sbcspi_pkg::ADDR_SPECIAL)
         reg_read = code;
      else if (a == sbcspi_pkg::ADDR_WDOG)
         reg_read = sbcspi_pkg::REG_RESET;
      else if (a == sbcspi_pkg::ADDR_MODE)
      begin
         reg_read = r[a];
         reg_read[sbcspi_pkg::MODE_DBG_BIT] = dbg;
      end
      else
         reg_read = r[a];
   endfunction

   // flag byte of a block, sub-address chosen by bit 7
   function automatic logic [7:0] flag_read(
      input logic [4:0]                   a,
      input logic                         hi,
      input sbcspi_pkg::sbcspi_flags_type f
   );
      logic [15:0] w;
      case (a)
         sbcspi_pkg::ADDR_CAN: w = f.can;
         sbcspi_pkg::ADDR_IO:  w = f.io;
         sbcspi_pkg::ADDR_IRQ: w = f.irq;
         sbcspi_pkg::ADDR_LIN: w = f.lin;
         default:              w = '0;
      endcase
      flag_read = hi ? w[15:8] : w[7:0];
   endfunction

   sbcspi_link u_link (
      .spiClk     (spiClk),
      .reset      (reset),
      .csN        (csN),
      .mosi       (mosi),
      .statusByte (status_q),
      .respLo     (respLo_q),
      .respHi     (respHi_q),
      .reqTog     (reqTog),
      .reqHead    (reqHead),
      .frameTog   (frameTog),
      .frameWord  (frameWord),
      .misoQ      (misoLink)
   );

   // select enters inverted so the stages' reset level means idle
   sbcspi_sync #(.WIDTH(6)) u_pinSync (
      .clk     (mclk),
      .reset   (reset),
      .asyncIn ({~csN, debugPin, ioPins}),
      .syncOut (pinSync)
   );

   sbcspi_sync #(.WIDTH(2)) u_togSync (
      .clk     (mclk),
      .reset   (reset),
      .asyncIn ({frameTog, reqTog}),
      .syncOut (togSync)
   );

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         reqSeen_q   <= 1'b0;
         frameSeen_q <= 1'b0;
      end
      else
      begin
         reqSeen_q   <= togSync[0];
         frameSeen_q <= togSync[1];
      end
   end

   assign reqEdge   = togSync[0] ^ reqSeen_q;
   assign frameEdge = togSync[1] ^ frameSeen_q;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         misoOe <= 1'b0;
      else
         misoOe <= pinSync[5];
   end

   // frame checks on the completed word
   always_comb
   begin
      writeOk  = 1'b0;
      readOk   = 1'b0;
      badFrame = 1'b0;
      case (fw.cmd)
         sbcspi_pkg::CMD_WRITE:
         begin
            writeOk = addr_mapped(fw.addr) && parity_ok(fw,
               regs_q[sbcspi_pkg::ADDR_INIT_MSC][sbcspi_pkg::PARITY_EN_BIT]);
            badFrame = ~writeOk;
         end
         sbcspi_pkg::CMD_READ, sbcspi_pkg::CMD_FLAG:
         begin
            readOk   = fw.pn && addr_mapped(fw.addr);
            badFrame = ~readOk;
         end
         sbcspi_pkg::CMD_RSVD:
            badFrame = 1'b1;
         default:
            badFrame = 1'b1;
      endcase
   end

   assign extStatus = {4'h0, |deviceFlags.can, |deviceFlags.io,
                       |deviceFlags.irq, |deviceFlags.lin};

   // answer bytes, ready before the link shifts out bit 7
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         respLo_q <= '0;
         respHi_q <= '0;
      end
      else if (reqEdge)
      begin
         case (reqHead.cmd)
            sbcspi_pkg::CMD_READ:
            begin
               respLo_q <= reg_read(reqHead.addr, regs_q, lfsr_q,
                                    debugMode);
               respHi_q <= {DEVICE_ID, pinSync[3:0]};
            end
            sbcspi_pkg::CMD_WRITE:
            begin
               respLo_q <= extStatus;
               respHi_q <= extStatus;
            end
            sbcspi_pkg::CMD_FLAG:
            begin
               respLo_q <= flag_read(reqHead.addr, 1'b0, deviceFlags);
               respHi_q <= flag_read(reqHead.addr, 1'b1, deviceFlags);
            end
            default:
            begin
               respLo_q <= '0;
               respHi_q <= '0;
            end
         endcase
      end
   end

   // free-running code source
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         lfsr_q <= sbcspi_pkg::LFSR_SEED;
      else if (lfsr_q[0])
         lfsr_q <= (lfsr_q >> 1) ^ sbcspi_pkg::LFSR_TAPS;
      else
         lfsr_q <= lfsr_q >> 1;
   end

   // code handed out is the one a special write must invert
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         random_q <= sbcspi_pkg::LFSR_SEED;
      else if (reqEdge && reqHead.cmd == sbcspi_pkg::CMD_READ &&
               reqHead.addr == sbcspi_pkg::ADDR_SPECIAL)
         random_q <= lfsr_q;
   end

   // register file
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         regs_q <= '0;
      else if (frameEdge && writeOk)
      begin
         if (fw.addr == sbcspi_pkg::ADDR_SPECIAL)
         begin
            if (fw.data == ~random_q)
               regs_q[fw.addr] <= fw.data;
         end
         else if (fw.addr != sbcspi_pkg::ADDR_WDOG)
            regs_q[fw.addr] <= fw.data;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         specialActive <= 1'b0;
      else if (frameEdge && writeOk &&
               fw.addr == sbcspi_pkg::ADDR_SPECIAL &&
               fw.data == ~random_q)
         specialActive <= 1'b1;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         wdRefresh <= 1'b0;
      else
         wdRefresh <= frameEdge && writeOk &&
                      fw.addr == sbcspi_pkg::ADDR_WDOG;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         lowPowerReq <= 1'b0;
      else
         lowPowerReq <= frameEdge && writeOk &&
                        fw.addr == sbcspi_pkg::ADDR_MODE;
   end

   // strap taken once both sync stages hold it; mode read-back leaves it
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         started_q <= '0;
         debugMode <= 1'b0;
      end
      else if (!started_q[2])
      begin
         started_q <= {started_q[1:0], 1'b1};
         debugMode <= pinSync[4];
      end
      else if (frameEdge && readOk && fw.cmd == sbcspi_pkg::CMD_READ &&
               !fw.data[sbcspi_pkg::SUB_BIT] &&
               fw.addr == sbcspi_pkg::ADDR_MODE)
         debugMode <= 1'b0;
   end

   // sticky error: set wins over the clear by a good read
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         spiErr_q <= 1'b0;
      else if (frameEdge && (badFrame ||
               (writeOk && fw.addr == sbcspi_pkg::ADDR_SPECIAL &&
                fw.data != ~random_q)))
         spiErr_q <= 1'b1;
      else if (frameEdge && readOk)
         spiErr_q <= 1'b0;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         status_q <= '0;
      else
      begin
         status_q                         <= '0;
         status_q[sbcspi_pkg::ST_SPI_ERR] <= spiErr_q;
         status_q[sbcspi_pkg::ST_DEBUG]   <= debugMode;
         status_q[sbcspi_pkg::ST_SPECIAL] <= specialActive;
         status_q[sbcspi_pkg::ST_LOWPWR]  <= |regs_q[sbcspi_pkg::ADDR_MODE];
      end
   end

endmodule
`default_nettype wire

// ===== verif/sbcspi_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none

module sbcspi_checker (
   input wire logic                             mclk,          // core clock
   input wire logic                             reset,         // async reset
   input wire logic                             spiClk,        // serial clock
   input wire logic                             csN,           // chip select
   input wire logic                             mosi,          // serial in
   input wire logic                             miso,          // serial out
   input wire logic                             misoOe,        // miso drive
   input wire logic [3:0]                       ioPins,        // pin levels
   input wire logic                             debugPin,      // strap
   input wire sbcspi_pkg::sbcspi_flags_type     deviceFlags,   // flags
   input wire logic [sbcspi_pkg::NUM_REGS-1:0][7:0] regImage,  // registers
   input wire logic                             wdRefresh,     // refresh
   input wire logic                             lowPowerReq,   // mode pulse
   input wire logic                             specialActive, // special
   input wire logic                             debugMode      // debug
);
   logic [4:0] bitCnt;

   // rising edges seen so far in the frame
   always_ff @(posedge spiClk or posedge csN)
   begin
      if (csN)
         bitCnt <= 5'h00;
      else if (bitCnt != 5'h1F)
         bitCnt <= bitCnt + 5'h01;
   end

   a_status_low_zero: assert property (@(posedge spiClk) disable iff (reset || csN)
      (bitCnt >= 5'h04 && bitCnt <= 5'h07) |-> !miso)
      else $error("fixed status low nibble not zero");
   a_oe_on_select: assert property (@(posedge mclk) disable iff (reset)
      $fell(csN) |-> ##[1:4] misoOe)
      else $error("miso not driven after select");
   a_oe_off_deselect: assert property (@(posedge mclk) disable iff (reset)
      $rose(csN) |-> ##[1:4] !misoOe)
      else $error("miso still driven after deselect");
   a_oe_off_idle: assert property (@(posedge mclk) disable iff (reset)
      csN [*5] |-> !misoOe)
      else $error("miso driven while idle");
   a_wd_one_pulse: assert property (@(posedge mclk) disable iff (reset)
      wdRefresh |=> !wdRefresh)
      else $error("refresh pulse too long");
   a_wd_after_frame: assert property (@(posedge mclk) disable iff (reset)
      wdRefresh |-> $past(misoOe, 8) && !lowPowerReq)
      else $error("refresh without frame");
   a_lp_one_pulse: assert property (@(posedge mclk) disable iff (reset)
      lowPowerReq |=> !lowPowerReq)
      else $error("mode pulse too long");
   a_lp_after_frame: assert property (@(posedge mclk) disable iff (reset)
      lowPowerReq |-> $past(misoOe, 8))
      else $error("mode pulse without frame");
   a_special_sticky: assert property (@(posedge mclk) disable iff (reset)
      specialActive |=> specialActive)
      else $error("special mode dropped");
   a_debug_strap_only: assert property (@(posedge mclk) disable iff (reset)
      $rose(debugMode) |-> $past(reset, 4))
      else $error("debug entered outside reset exit");
   a_regs_after_frame: assert property (@(posedge mclk) disable iff (reset)
      $changed(regImage) |-> $past(misoOe, 8))
      else $error("register changed without frame");
   a_regs_reset_zero: assert property (@(posedge mclk) disable iff (reset)
      $past(reset) |-> regImage == '0 && !specialActive)
      else $error("registers not cleared by reset");
endmodule

bind sbcspi_command_decoder sbcspi_checker i_sbcspi_checker (.mclk(mclk),
   .reset(reset), .spiClk(spiClk), .csN(csN), .mosi(mosi), .miso(miso),
   .misoOe(misoOe), .ioPins(ioPins), .debugPin(debugPin),
   .deviceFlags(deviceFlags), .regImage(regImage), .wdRefresh(wdRefresh),
   .lowPowerReq(lowPowerReq), .specialActive(specialActive),
   .debugMode(debugMode));

`default_nettype wire

// ===== verif/sbcspi_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module sbcspi_host_model (
   output logic      spiClk, // serial clock, still between frames
   output logic      csN,    // chip select
   output logic      mosi,   // serial data to device
   input  wire logic miso,   // serial data from device
   input  wire logic misoOe  // device drives miso
);
   initial
   begin
      spiClk = 1'b0;
      csN    = 1'b1;
      mosi   = 1'b0;
   end

   // one frame, mode 0, 30 ns clock, msb first
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      int i;
      csN = 1'b0;
      #30;
      for (i = 15; i >= 0; i--)
      begin
         mosi = tx[i];
         #15;
         spiClk = 1'b1;
         rx[i]  = misoOe ? miso : 1'bx;
         #15;
         spiClk = 1'b0;
      end
      #15;
      csN  = 1'b1;
      mosi = ~tx[0];
      #200;
   endtask
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   localparam logic [3:0] DEV_ID = 4'h3; // arbitrary identity value
   logic                         mclk;
   logic                         reset;
   logic                         spiClk;
   logic                         csN;
   logic                         mosi;
   logic                         miso;
   logic                         misoOe;
   logic [3:0]                   ioPins;
   logic                         debugPin;
   sbcspi_pkg::sbcspi_flags_type deviceFlags;
   logic [19:0][7:0]             regImage;
   logic                         wdRefresh;
   logic                         lowPowerReq;
   logic                         specialActive;
   logic                         debugMode;
   int                           num_errors;
   int                           compares;
   int                           a;
   logic [7:0]                   wdCount;
   logic [7:0]                   lpCount;
   logic [19:0][7:0]             expReg;
   logic [3:0]                   stNow;
   logic [3:0]                   stShown;
   logic [15:0]                  rx;
   logic [7:0]                   code;
   logic [15:0]                  badTx [0:2];

   sbcspi_command_decoder #(.DEVICE_ID(DEV_ID)) i_sbcspi_command_decoder (
      .mclk(mclk), .reset(reset), .spiClk(spiClk), .csN(csN), .mosi(mosi),
      .miso(miso), .misoOe(misoOe), .ioPins(ioPins), .debugPin(debugPin),
      .deviceFlags(deviceFlags), .regImage(regImage),
      .wdRefresh(wdRefresh), .lowPowerReq(lowPowerReq),
      .specialActive(specialActive), .debugMode(debugMode));

   sbcspi_host_model i_sbcspi_host_model (.spiClk(spiClk), .csN(csN),
      .mosi(mosi), .miso(miso), .misoOe(misoOe));

   always #4 mclk = ~mclk;

   always @(posedge mclk)
   begin
      if (wdRefresh === 1'b1)
         wdCount <= wdCount + 8'h01;
      if (lowPowerReq === 1'b1)
         lpCount <= lpCount + 8'h01;
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h not %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] ext();
      return {4'h0, |deviceFlags.can, |deviceFlags.io, |deviceFlags.irq,
              |deviceFlags.lin};
   endfunction

   // status shows state as it stood when the previous frame ended
   task automatic frame(input logic [15:0] tx, input logic [7:0] expLo,
                        input logic chkLo, input logic bad);
      @(negedge mclk);
      i_sbcspi_host_model.xfer(tx, rx);
      chk8(rx[15:8], {stShown, 4'h0});
      if (chkLo)
         chk8(rx[7:0], expLo);
      stShown = stNow;
      if (bad)
         stNow[3] = 1'b1;
      else if (tx[15] == tx[14])
         stNow[3] = 1'b0;
   endtask

   // m[0] spoils parity, m[1] marks a refused write
   task automatic wr(input logic [4:0] ad, input logic [7:0] d,
                     input logic [1:0] m);
      logic [15:0] tx;
      tx = {2'b01, ad, 1'b0, d};
      if (expReg[8][6])
         tx[8] = ~^tx;
      tx[8] = tx[8] ^ m[0];
      frame(tx, ext(), 1'b1, m != 2'b00);
      if (m == 2'b00 && ad != 5'h0D)
         expReg[ad] = d;
   endtask

   task automatic rd(input logic [4:0] ad);
      logic [7:0] e;
      e = expReg[ad];
      if (ad == 5'h0E)
         e[7] = stNow[2];
      frame({2'b00, ad, 1'b1, 8'h00}, e, 1'b1, 1'b0);
   endtask

   task automatic fl(input logic [4:0] ad, input logic h);
      logic [15:0] f;
      f = deviceFlags[16 * (19 - ad) +: 16];
      frame({2'b11, ad, 1'b1, h, 7'h00}, h ? {f[7], f[14:8]} : f[7:0],
            1'b1, 1'b0);
   endtask

   initial
   begin
      #300000;
      num_errors++;
      test_done();
   end

   initial
   begin
      mclk        = 1'b0;
      reset       = 1'b1;
      ioPins      = 4'hC;
      debugPin    = 1'b1;
      deviceFlags = {16'h4281, 16'h0000, 16'h1C3E, 16'h0000};
      num_errors  = 0;
      compares    = 0;
      wdCount     = 8'h00;
      lpCount     = 8'h00;
      stNow       = 4'b0100;
      stShown     = 4'b0000;
      badTx       = '{16'h82FF, 16'h2900, 16'h0200};
      expReg      = '0;
      repeat (5) @(posedge mclk);
      @(negedge mclk) reset = 1'b0;
      repeat (4) @(negedge mclk);
      for (a = 0; a < 20; a++)
         if (a != 9 && a != 14)
            wr(a[4:0], 8'h5A ^ {a[4:0], 3'b000}, 2'b00);
      for (a = 0; a < 20; a++)
         if (a != 9 && a != 14)
            rd(a[4:0]);
      for (a = 0; a < 20; a++)
         if (a != 9 && a != 13)
            chk8(regImage[a], expReg[a]);
      chk8(wdCount, 8'h01);
      $display("test register store done");
      frame(16'h0180, {expReg[0][7], DEV_ID[2:0], ioPins}, 1'b1, 1'b0);
      for (a = 16; a < 20; a++)
      begin
         fl(a[4:0], 1'b0);
         fl(a[4:0], 1'b1);
      end
      $display("test identity and flags done");
      for (a = 0; a < 3; a++)
      begin
         frame(badTx[a], 8'h00, 1'b0, 1'b1);
         rd(5'h01);
         chk8(regImage[1], expReg[1]);
      end
      $display("test refused frames done");
      frame(16'h1300, 8'h00, 1'b0, 1'b0);
      code = rx[7:0];
      wr(5'h09, code, 2'b10);
      chk1(specialActive, 1'b0);
      frame(16'h1300, 8'h00, 1'b0, 1'b0);
      code = rx[7:0];
      wr(5'h09, ~code, 2'b00);
      stNow[1] = 1'b1;
      chk1(specialActive, 1'b1);
      $display("test special mode done");
      wr(5'h0E, 8'h03, 2'b00);
      stNow[0] = 1'b1;
      chk8(lpCount, 8'h01);
      rd(5'h0E);
      stNow[2] = 1'b0;
      chk1(debugMode, 1'b0);
      $display("test power mode done");
      wr(5'h08, 8'h40, 2'b00);
      wr(5'h01, 8'h3C, 2'b00);
      wr(5'h01, 8'hC3, 2'b01);
      rd(5'h01);
      rd(5'h00);
      $display("test parity done");
      test_done();
   end
endmodule

`default_nettype wire
